// ---- usm_link_model.sv ----
`timescale 1ns/1ps
// ==========================================
// Link controller side of the shared data pins
module usm_link_model (
  input wire logic clk,
  input wire logic three_wire,
  input wire logic tx_en,
  input wire logic serial_transmit_data,
  input wire logic serial_transmit_single_zero,
  input wire logic dir,
  input wire logic [7:0] dev_out,
  input wire logic [7:0] dev_oe,
  output logic [7:0] bus
);
  logic [7:0] link_oe;
  logic [7:0] link_val;
  logic [7:0] floating = 8'h55;
  // Pins nobody drives toggle, so a stale level never passes for data
  always @(posedge clk) floating <= ~floating;
  always_comb begin
    if (!dir) begin
      link_oe = 8'hff;
      link_val = 8'h00;
    end else begin
      link_val = {5'h00, serial_transmit_single_zero, serial_transmit_data, tx_en};
      link_oe = three_wire ? {5'h00, tx_en, tx_en, 1'b1} : 8'h07;
    end
    for (int i = 0; i < 8; i++) begin
      bus[i] = dev_oe[i] ? dev_out[i] : (link_oe[i] ? link_val[i] : floating[i]);
    end
  end
endmodule : usm_link_model

// ---- usm_pkg.sv ----
package usm_pkg;
  localparam int DATA_W = 8;
  localparam int SYNC_STAGES = 2;
  // Bus bit positions in the serial maps
  localparam int BIT_TX_EN = 0;
  localparam int BIT_DAT = 1;
  localparam int BIT_SE0 = 2;
  localparam int BIT_INT = 3;
  localparam int BIT_PLUS_LINE_RECEIVE = 4;
  localparam int BIT_MINUS_LINE_RECEIVE = 5;
  localparam int BIT_DIFFERENTIAL_RECEIVE = 6;
  localparam int BIT_SPARE = 7;
  // Operating mode field codes
  localparam logic [1:0] OPERATING_MODE_FIELD_NORMAL = 2'h0;
  localparam logic [1:0] OPERATING_MODE_FIELD_NODRIVE = 2'h1;
  localparam logic [1:0] OPERATING_MODE_FIELD_CHIRP = 2'h2;
  // Transceiver speed select codes
  localparam logic [1:0] XCVR_HS = 2'h0;
  localparam logic [1:0] XCVR_FS = 2'h1;
  localparam logic [1:0] XCVR_LS = 2'h2;
  localparam logic [7:0] BUS_IDLE = 8'h00;
  // Device-driven bits in either serial map: interrupt and everything above it
  localparam logic [7:0] SERIAL_OE = 8'hf8;
  typedef enum logic [1:0] {
    USM_SYNC,
    USM_SIX,
    USM_THREE,
    USM_EXIT
  } usm_state_e;
endpackage : usm_pkg

// ---- usm_sync.sv ----
`timescale 1ns/1ps
// Two flip-flop synchroniser, one per bit
module usm_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;
  logic [W-1:0] next_meta;
  logic [W-1:0] next_q;

  always_comb begin
    next_meta = d;
    next_q = meta;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= next_meta;
      q <= next_q;
    end
  end
endmodule : usm_sync

// ---- usm_term.sv ----
`timescale 1ns/1ps
// Resistor enables decoded from the transceiver control bits
module usm_term (
  input wire logic [1:0] xcvr_sel,
  input wire logic term_sel,
  input wire logic [1:0] op_mode,
  input wire logic dp_pd,
  input wire logic dm_pd,
  output logic pu_dp,
  output logic pd_dp,
  output logic pd_dm,
  output logic hs_term
);
  always_comb begin
    pd_dp = dp_pd;
    pd_dm = dm_pd;
    // Pull-up only for a peripheral that signals at full or low speed, or chirps
    pu_dp = term_sel && !(dp_pd && dm_pd);
    // High-speed termination whenever high-speed select with no full-speed term, except in no-drive mode
    hs_term = (xcvr_sel == usm_pkg::XCVR_HS) && !term_sel;
    if (op_mode == usm_pkg::OPERATING_MODE_FIELD_NODRIVE) begin
      pu_dp = 1'b0;
      pd_dp = 1'b0;
      pd_dm = 1'b0;
      hs_term = 1'b0;
    end
  end
endmodule : usm_term

// ---- usm_top.sv ----
`timescale 1ns/1ps
// Summary of operation
// - Stop signal ends six-wire mode; bus returns to synchronous use.
// - Six-wire: device drives plus, minus and differential receive bits.
// - Both serial modes: bit three is active-high unmasked interrupt.
// - Unused bus bits are driven low in both serial modes.
// - Three-wire mode entered by enable bit, left by stop signal.
// - Three-wire data bit: link drives while enabled, device otherwise.
// - Three-wire zero bit: link drives while enabled, device otherwise.
// - Resistor enables come only from the five control fields.
// - Enables drive pull-up, two pull-downs and high-speed terminations.
// - No-drive operating mode turns all four resistor enables off.
// - Host high-speed settings: pull-downs and termination on, pull-up off.
// - Host full or low speed: pull-downs only.
// - Power-up settings enable only the two pull-downs.
// - Stop high in serial mode ends it; bus returns to synchronous mode once stop drops.
// - Direction stays asserted throughout serial modes.
// - Next-data output unused in serial modes.
module usm_top (
  input wire logic CLOCK,
  input wire logic RESET,
  input wire logic STOP,
  input wire logic [7:0] DATA_IN,
  output logic [7:0] DATA_OUT,
  output logic [7:0] DATA_OE,
  output logic DIRECTION,
  output logic NEXT_DATA,
  input wire logic SET_SIX_WIRE,
  input wire logic SET_THREE_WIRE,
  output logic SIX_WIRE_SERIAL_ENABLE,
  output logic THREE_WIRE_SERIAL_ENABLE,
  input wire logic IRQ_ACTIVE,
  input wire logic PLUS_LINE_RECEIVE,
  input wire logic MINUS_LINE_RECEIVE,
  input wire logic DIFFERENTIAL_RECEIVE,
  output logic SERIAL_TRANSMIT_ENABLE,
  output logic SERIAL_TRANSMIT_DATA,
  output logic SERIAL_TRANSMIT_SINGLE_ZERO,
  input wire logic [1:0] TRANSCEIVER_SPEED_SELECT,
  input wire logic TERMINATION_SELECT,
  input wire logic [1:0] OPERATING_MODE_FIELD,
  input wire logic PLUS_LINE_PULLDOWN_BIT,
  input wire logic MINUS_LINE_PULLDOWN_BIT,
  output logic PLUS_PULLUP_ENABLE,
  output logic PLUS_PULLDOWN_ENABLE,
  output logic MINUS_PULLDOWN_ENABLE,
  output logic HS_TERMINATION_ENABLE
);
  // ==========================================================
  // Input synchronisers
  // ==========================================================
  localparam int NSYNC = usm_pkg::DATA_W + 5;
  logic [NSYNC-1:0] raw_in;
  logic [NSYNC-1:0] syn_in;
  logic stop_s;
  logic irq_s;
  logic plus_line_receive_s;
  logic minus_line_receive_s;
  logic differential_receive_s;
  logic [7:0] din_s;

  // Pins and analog receivers are asynchronous to CLOCK
  assign raw_in = {STOP, IRQ_ACTIVE, PLUS_LINE_RECEIVE, MINUS_LINE_RECEIVE,
                   DIFFERENTIAL_RECEIVE, DATA_IN};
  usm_sync #(.W(NSYNC)) u_sync (
    .clk(CLOCK),
    .rst(RESET),
    .d(raw_in),
    .q(syn_in)
  );
  assign stop_s = syn_in[NSYNC-1];
  assign irq_s = syn_in[NSYNC-2];
  assign plus_line_receive_s = syn_in[NSYNC-3];
  assign minus_line_receive_s = syn_in[NSYNC-4];
  assign differential_receive_s = syn_in[NSYNC-5];
  assign din_s = syn_in[7:0];

  // ==========================================================
  // Mode state machine
  // ==========================================================
  usm_pkg::usm_state_e state;
  usm_pkg::usm_state_e next_state;

  always_comb begin
    next_state = state;
    case (state)
      usm_pkg::USM_SYNC: begin
        if (SET_SIX_WIRE) begin
          next_state = usm_pkg::USM_SIX;
        end else if (SET_THREE_WIRE) begin
          next_state = usm_pkg::USM_THREE;
        end
      end
      usm_pkg::USM_SIX: begin
        if (stop_s) begin
          next_state = usm_pkg::USM_EXIT;
        end
      end
      usm_pkg::USM_THREE: begin
        if (stop_s) begin
          next_state = usm_pkg::USM_EXIT;
        end
      end
      usm_pkg::USM_EXIT: begin
        // Wait for stop to drop so a held stop does not re-trigger
        if (!stop_s) begin
          next_state = usm_pkg::USM_SYNC;
        end
      end
      default: next_state = usm_pkg::USM_SYNC;
    endcase
  end

  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      state <= usm_pkg::USM_SYNC;
    end else begin
      state <= next_state;
    end
  end

  // ==========================================================
  // Bus mapping
  // ==========================================================
  logic six;
  logic three;
  logic tx_en;
  logic [7:0] next_dout;
  logic [7:0] next_doe;
  logic next_dir;
  logic next_six_en;
  logic next_three_en;
  logic next_tx_en;
  logic next_serial_transmit_data;
  logic next_serial_transmit_single_zero;

  assign six = (state == usm_pkg::USM_SIX);
  assign three = (state == usm_pkg::USM_THREE);
  assign tx_en = din_s[usm_pkg::BIT_TX_EN];

  always_comb begin
    next_dout = usm_pkg::BUS_IDLE;
    next_doe = usm_pkg::BUS_IDLE;
    next_tx_en = 1'b0;
    next_serial_transmit_data = 1'b0;
    next_serial_transmit_single_zero = 1'b0;
    if (six) begin
      next_doe = usm_pkg::SERIAL_OE;
      next_dout[usm_pkg::BIT_INT] = irq_s;
      next_dout[usm_pkg::BIT_PLUS_LINE_RECEIVE] = plus_line_receive_s;
      next_dout[usm_pkg::BIT_MINUS_LINE_RECEIVE] = minus_line_receive_s;
      next_dout[usm_pkg::BIT_DIFFERENTIAL_RECEIVE] = differential_receive_s;
      next_tx_en = tx_en;
      next_serial_transmit_data = din_s[usm_pkg::BIT_DAT];
      next_serial_transmit_single_zero = din_s[usm_pkg::BIT_SE0];
    end else if (three) begin
      next_doe = usm_pkg::SERIAL_OE;
      next_dout[usm_pkg::BIT_INT] = irq_s;
      next_tx_en = tx_en;
      // The link's enable arrives through the synchroniser, so the shared
      // bits change hands three cycles after the link flips its enable
      if (tx_en) begin
        next_serial_transmit_data = din_s[usm_pkg::BIT_DAT];
        next_serial_transmit_single_zero = din_s[usm_pkg::BIT_SE0];
      end else begin
        next_doe[usm_pkg::BIT_DAT] = 1'b1;
        next_doe[usm_pkg::BIT_SE0] = 1'b1;
        next_dout[usm_pkg::BIT_DAT] = differential_receive_s;
        next_dout[usm_pkg::BIT_SE0] = !plus_line_receive_s && !minus_line_receive_s;
      end
    end
    next_dir = six || three || (state == usm_pkg::USM_EXIT);
    // Enable bits mirror the mode, so exit by stop clears them
    next_six_en = (next_state == usm_pkg::USM_SIX);
    next_three_en = (next_state == usm_pkg::USM_THREE);
  end

  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      DATA_OUT <= usm_pkg::BUS_IDLE;
      DATA_OE <= usm_pkg::BUS_IDLE;
      DIRECTION <= 1'b0;
      NEXT_DATA <= 1'b0;
      SIX_WIRE_SERIAL_ENABLE <= 1'b0;
      THREE_WIRE_SERIAL_ENABLE <= 1'b0;
      SERIAL_TRANSMIT_ENABLE <= 1'b0;
      SERIAL_TRANSMIT_DATA <= 1'b0;
      SERIAL_TRANSMIT_SINGLE_ZERO <= 1'b0;
    end else begin
      DATA_OUT <= next_dout;
      DATA_OE <= next_doe;
      DIRECTION <= next_dir;
      NEXT_DATA <= 1'b0;
      SIX_WIRE_SERIAL_ENABLE <= next_six_en;
      THREE_WIRE_SERIAL_ENABLE <= next_three_en;
      SERIAL_TRANSMIT_ENABLE <= next_tx_en;
      SERIAL_TRANSMIT_DATA <= next_serial_transmit_data;
      SERIAL_TRANSMIT_SINGLE_ZERO <= next_serial_transmit_single_zero;
    end
  end

  // ==========================================================
  // Termination control
  // ==========================================================
  logic pu_dp;
  logic pd_dp;
  logic pd_dm;
  logic hs_term;

  usm_term u_term (
    .xcvr_sel(TRANSCEIVER_SPEED_SELECT),
    .term_sel(TERMINATION_SELECT),
    .op_mode(OPERATING_MODE_FIELD),
    .dp_pd(PLUS_LINE_PULLDOWN_BIT),
    .dm_pd(MINUS_LINE_PULLDOWN_BIT),
    .pu_dp(pu_dp),
    .pd_dp(pd_dp),
    .pd_dm(pd_dm),
    .hs_term(hs_term)
  );

  // Registered for glitch-free resistor switching, one cycle of latency
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      PLUS_PULLUP_ENABLE <= 1'b0;
      PLUS_PULLDOWN_ENABLE <= 1'b0;
      MINUS_PULLDOWN_ENABLE <= 1'b0;
      HS_TERMINATION_ENABLE <= 1'b0;
    end else begin
      PLUS_PULLUP_ENABLE <= pu_dp;
      PLUS_PULLDOWN_ENABLE <= pd_dp;
      MINUS_PULLDOWN_ENABLE <= pd_dm;
      HS_TERMINATION_ENABLE <= hs_term;
    end
  end

  // ==========================================================
  // Assertions
  // ==========================================================
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RESET);

  a_dir_serial: assert property ((six || three) |=> DIRECTION)
    else $error("Direction low in serial mode");
  a_next_idle: assert property ((six || three) |=> !NEXT_DATA)
    else $error("Next-data used in serial mode");
  a_stop_exit: assert property (((six || three) && stop_s) |=>
    (state == usm_pkg::USM_EXIT))
    else $error("Stop did not end serial mode");
  a_enable_clear: assert property ((state == usm_pkg::USM_EXIT) |=>
    (!SIX_WIRE_SERIAL_ENABLE && !THREE_WIRE_SERIAL_ENABLE))
    else $error("Serial enable not cleared on exit");
  a_int_map: assert property ((six || three) |=>
    (DATA_OUT[usm_pkg::BIT_INT] == $past(irq_s)))
    else $error("Interrupt bit wrong");
  a_rx_map: assert property (six |=>
    (DATA_OUT[usm_pkg::BIT_DIFFERENTIAL_RECEIVE] == $past(differential_receive_s)))
    else $error("Differential receive bit wrong");
  a_spare_low: assert property ((six || three) |=>
    (DATA_OUT[usm_pkg::BIT_SPARE] == 1'b0 && DATA_OE[usm_pkg::BIT_SPARE]))
    else $error("Unused bit not driven low");
  a_three_turn: assert property ((three && tx_en) |=>
    !DATA_OE[usm_pkg::BIT_DAT])
    else $error("Device drove data while link transmits");
  a_nodrive_off: assert property ((OPERATING_MODE_FIELD == usm_pkg::OPERATING_MODE_FIELD_NODRIVE)
    |=> !(PLUS_PULLUP_ENABLE || PLUS_PULLDOWN_ENABLE || MINUS_PULLDOWN_ENABLE
    || HS_TERMINATION_ENABLE))
    else $error("Resistors on in no-drive mode");
  a_host_pd: assert property ((PLUS_LINE_PULLDOWN_BIT && MINUS_LINE_PULLDOWN_BIT
    && OPERATING_MODE_FIELD != usm_pkg::OPERATING_MODE_FIELD_NODRIVE)
    |=> (PLUS_PULLDOWN_ENABLE && MINUS_PULLDOWN_ENABLE && !PLUS_PULLUP_ENABLE))
    else $error("Host pull-down settings wrong");
  a_host_hs: assert property ((PLUS_LINE_PULLDOWN_BIT && MINUS_LINE_PULLDOWN_BIT
    && TRANSCEIVER_SPEED_SELECT == usm_pkg::XCVR_HS && !TERMINATION_SELECT
    && OPERATING_MODE_FIELD != usm_pkg::OPERATING_MODE_FIELD_NODRIVE) |=> HS_TERMINATION_ENABLE)
    else $error("Host termination off");
  a_six_oe: assert property (six |=> (DATA_OE == usm_pkg::SERIAL_OE))
    else $error("Six-wire drive mask wrong");
  a_rx_lines: assert property (six |=>
    (DATA_OUT[usm_pkg::BIT_PLUS_LINE_RECEIVE] == $past(plus_line_receive_s)
    && DATA_OUT[usm_pkg::BIT_MINUS_LINE_RECEIVE] == $past(minus_line_receive_s)))
    else $error("Single-ended receive bits wrong");
  a_three_drive: assert property ((three && !tx_en) |=>
    (DATA_OE[usm_pkg::BIT_DAT] && DATA_OE[usm_pkg::BIT_SE0]))
    else $error("Device not driving shared bits");
  a_dat_map: assert property ((three && !tx_en) |=>
    (DATA_OUT[usm_pkg::BIT_DAT] == $past(differential_receive_s)))
    else $error("Received data bit wrong");
  a_se0_map: assert property ((three && !tx_en && !plus_line_receive_s && !minus_line_receive_s) |=>
    DATA_OUT[usm_pkg::BIT_SE0])
    else $error("Single-ended zero not reported");
  a_bus_return: assert property ((state == usm_pkg::USM_SYNC) |=>
    (DATA_OE == usm_pkg::BUS_IDLE))
    else $error("Bus not returned after serial mode");

  c_six: cover property (six ##1 stop_s ##1 (state == usm_pkg::USM_EXIT));
  c_three: cover property (three && !tx_en);
  c_hs_term: cover property (HS_TERMINATION_ENABLE && PLUS_PULLDOWN_ENABLE);
  c_three_tx: cover property (three && tx_en);
  c_nodrive: cover property (OPERATING_MODE_FIELD == usm_pkg::OPERATING_MODE_FIELD_NODRIVE);
endmodule : usm_top

// ---- usm_top_tb.sv ----
`timescale 1ns/1ps
module usm_top_tb;
  logic CLOCK = 1'b0;
  logic RESET = 1'b1;
  logic STOP = 1'b0, SET_SIX_WIRE = 1'b0, SET_THREE_WIRE = 1'b0, IRQ_ACTIVE = 1'b0;
  logic PLUS_LINE_RECEIVE = 1'b0, MINUS_LINE_RECEIVE = 1'b0, DIFFERENTIAL_RECEIVE = 1'b0;
  logic [1:0] TRANSCEIVER_SPEED_SELECT = 2'h0, OPERATING_MODE_FIELD = 2'h0;
  logic TERMINATION_SELECT = 1'b0, PLUS_LINE_PULLDOWN_BIT = 1'b0, MINUS_LINE_PULLDOWN_BIT = 1'b0;
  logic three = 1'b0, tx_en = 1'b0, serial_transmit_data = 1'b0, serial_transmit_single_zero = 1'b0;
  logic [7:0] DATA_IN, DATA_OUT, DATA_OE;
  logic DIRECTION, NEXT_DATA, SIX_WIRE_SERIAL_ENABLE, THREE_WIRE_SERIAL_ENABLE;
  logic SERIAL_TRANSMIT_ENABLE, SERIAL_TRANSMIT_DATA, SERIAL_TRANSMIT_SINGLE_ZERO;
  logic PLUS_PULLUP_ENABLE, PLUS_PULLDOWN_ENABLE, MINUS_PULLDOWN_ENABLE, HS_TERMINATION_ENABLE;
  int err_count = 0;
  int checked = 0;
  // Rows: speed, term, mode, plus pd, minus pd, then pull-up, pd plus, pd minus, hs term
  logic [10:0] rows [11] = '{11'h770, 11'h070, 11'h236, 11'h0b7, 11'h037, 11'h736,
                             11'h536, 11'h188, 11'h001, 11'h308, 11'h19a};

  usm_top i_usm_top (.CLOCK(CLOCK), .RESET(RESET), .STOP(STOP), .DATA_IN(DATA_IN),
    .DATA_OUT(DATA_OUT), .DATA_OE(DATA_OE), .DIRECTION(DIRECTION), .NEXT_DATA(NEXT_DATA),
    .SET_SIX_WIRE(SET_SIX_WIRE), .SET_THREE_WIRE(SET_THREE_WIRE),
    .SIX_WIRE_SERIAL_ENABLE(SIX_WIRE_SERIAL_ENABLE),
    .THREE_WIRE_SERIAL_ENABLE(THREE_WIRE_SERIAL_ENABLE), .IRQ_ACTIVE(IRQ_ACTIVE),
    .PLUS_LINE_RECEIVE(PLUS_LINE_RECEIVE), .MINUS_LINE_RECEIVE(MINUS_LINE_RECEIVE),
    .DIFFERENTIAL_RECEIVE(DIFFERENTIAL_RECEIVE), .SERIAL_TRANSMIT_ENABLE(SERIAL_TRANSMIT_ENABLE),
    .SERIAL_TRANSMIT_DATA(SERIAL_TRANSMIT_DATA),
    .SERIAL_TRANSMIT_SINGLE_ZERO(SERIAL_TRANSMIT_SINGLE_ZERO),
    .TRANSCEIVER_SPEED_SELECT(TRANSCEIVER_SPEED_SELECT), .TERMINATION_SELECT(TERMINATION_SELECT),
    .OPERATING_MODE_FIELD(OPERATING_MODE_FIELD), .PLUS_LINE_PULLDOWN_BIT(PLUS_LINE_PULLDOWN_BIT),
    .MINUS_LINE_PULLDOWN_BIT(MINUS_LINE_PULLDOWN_BIT), .PLUS_PULLUP_ENABLE(PLUS_PULLUP_ENABLE),
    .PLUS_PULLDOWN_ENABLE(PLUS_PULLDOWN_ENABLE), .MINUS_PULLDOWN_ENABLE(MINUS_PULLDOWN_ENABLE),
    .HS_TERMINATION_ENABLE(HS_TERMINATION_ENABLE));

  usm_link_model i_usm_link_model (.clk(CLOCK), .three_wire(three), .tx_en(tx_en),
    .serial_transmit_data(serial_transmit_data), .serial_transmit_single_zero(serial_transmit_single_zero), .dir(DIRECTION), .dev_out(DATA_OUT), .dev_oe(DATA_OE),
    .bus(DATA_IN));

  // ==========================================
  // Shared tasks
  task automatic tick(input int n);
    repeat (n) @(posedge CLOCK);
  endtask : tick

  // Outputs are sampled half a cycle after the edge, once they have settled
  task automatic look();
    @(negedge CLOCK);
  endtask : look

  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic conclude();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : conclude

  task automatic rx(input logic irq, input logic dp, input logic dm, input logic rcv);
    IRQ_ACTIVE <= irq;
    PLUS_LINE_RECEIVE <= dp;
    MINUS_LINE_RECEIVE <= dm;
    DIFFERENTIAL_RECEIVE <= rcv;
  endtask : rx

  task automatic tx(input logic en, input logic dat, input logic se0);
    tx_en <= en;
    serial_transmit_data <= dat;
    serial_transmit_single_zero <= se0;
  endtask : tx

  // ==========================================
  // Scenarios
  task automatic t_reset();
    look();
    chk("direction", DIRECTION, 8'h00);
    chk("bus enable", DATA_OE, 8'h00);
    chk("serial enables", {SIX_WIRE_SERIAL_ENABLE, THREE_WIRE_SERIAL_ENABLE}, 8'h00);
    $display("done reset");
  endtask : t_reset

  // Stop held high ends serial use; the bus comes back only once stop drops
  task automatic t_stop();
    tick(1);
    STOP <= 1'b1;
    tick(6);
    look();
    chk("enables after stop", {SIX_WIRE_SERIAL_ENABLE, THREE_WIRE_SERIAL_ENABLE}, 8'h00);
    chk("direction in exit", DIRECTION, 8'h01);
    tick(1);
    STOP <= 1'b0;
    tick(6);
    look();
    chk("direction back", DIRECTION, 8'h00);
    chk("bus released", DATA_OE, 8'h00);
    three <= 1'b0;
    $display("done stop");
  endtask : t_stop

  task automatic t_six();
    tick(1);
    rx(1'b1, 1'b1, 1'b0, 1'b1);
    tx(1'b1, 1'b0, 1'b1);
    SET_SIX_WIRE <= 1'b1;
    tick(1);
    SET_SIX_WIRE <= 1'b0;
    look();
    chk("six enable", SIX_WIRE_SERIAL_ENABLE, 8'h01);
    tick(6);
    look();
    chk("direction", DIRECTION, 8'h01);
    chk("six oe", DATA_OE, 8'hf8);
    chk("six out", DATA_OUT, 8'h58);
    chk("six tx", {SERIAL_TRANSMIT_ENABLE, SERIAL_TRANSMIT_DATA,
        SERIAL_TRANSMIT_SINGLE_ZERO}, 8'h05);
    chk("next data", NEXT_DATA, 8'h00);
    tick(1);
    rx(1'b0, 1'b0, 1'b1, 1'b0);
    tx(1'b0, 1'b1, 1'b0);
    SET_THREE_WIRE <= 1'b1;
    tick(1);
    SET_THREE_WIRE <= 1'b0;
    tick(6);
    look();
    chk("refused three", THREE_WIRE_SERIAL_ENABLE, 8'h00);
    chk("six out flipped", DATA_OUT, 8'h20);
    chk("six tx flipped", {SERIAL_TRANSMIT_ENABLE, SERIAL_TRANSMIT_DATA,
        SERIAL_TRANSMIT_SINGLE_ZERO}, 8'h02);
    $display("done six wire");
  endtask : t_six

  task automatic t_three();
    tick(1);
    rx(1'b1, 1'b0, 1'b0, 1'b1);
    tx(1'b0, 1'b0, 1'b0);
    three <= 1'b1;
    SET_THREE_WIRE <= 1'b1;
    tick(1);
    SET_THREE_WIRE <= 1'b0;
    look();
    chk("three enable", {SIX_WIRE_SERIAL_ENABLE, THREE_WIRE_SERIAL_ENABLE}, 8'h01);
    tick(6);
    look();
    chk("three rx oe", DATA_OE, 8'hfe);
    chk("three rx out", DATA_OUT, 8'h0e);
    tick(1);
    rx(1'b0, 1'b1, 1'b0, 1'b0);
    tick(6);
    look();
    chk("three rx idle", DATA_OUT, 8'h00);
    tick(1);
    tx(1'b1, 1'b1, 1'b0);
    tick(6);
    look();
    chk("three tx oe", DATA_OE, 8'hf8);
    chk("three tx out", DATA_OUT & 8'hf8, 8'h00);
    chk("three tx", {SERIAL_TRANSMIT_ENABLE, SERIAL_TRANSMIT_DATA,
        SERIAL_TRANSMIT_SINGLE_ZERO}, 8'h06);
    $display("done three wire");
  endtask : t_three

  task automatic t_term();
    foreach (rows[k]) begin
      tick(1);
      {TRANSCEIVER_SPEED_SELECT, TERMINATION_SELECT, OPERATING_MODE_FIELD,
          PLUS_LINE_PULLDOWN_BIT, MINUS_LINE_PULLDOWN_BIT} <= rows[k][10:4];
      tick(2);
      look();
      chk("resistors", {PLUS_PULLUP_ENABLE, PLUS_PULLDOWN_ENABLE, MINUS_PULLDOWN_ENABLE,
          HS_TERMINATION_ENABLE}, {4'h0, rows[k][3:0]});
    end
    $display("done termination");
  endtask : t_term

  // ==========================================
  // Clock, watchdog and main sequence
  initial begin
    forever #25 CLOCK = ~CLOCK;
  end

  // Whole run needs some 100 cycles; twenty times that means a hang
  initial begin
    tick(2000);
    err_count++;
    conclude();
  end

  initial begin
    tick(2);
    RESET <= 1'b0;
    t_reset();
    t_six();
    t_stop();
    t_three();
    t_stop();
    t_term();
    conclude();
  end
endmodule : usm_top_tb
